// *** core/frs_sequencer.sv ***
// Flash row erase / latch load / row program sequencer
`timescale 1ns/1ps
module frs_sequencer
  import frs_pkg::*;
#(
  parameter int ERASE_CYCLES = ERASE_CYC,
  parameter int WRITE_CYCLES = WRITE_CYC
)
(
  // Clock and resets
  input wire logic clk,
  input wire logic resetn,
  input wire logic por_n,
  // Control and unlock writes
  input wire logic ctrl_we,
  input wire logic [7:0] ctrl_wdata,
  output logic [7:0] ctrl_rdata,
  input wire logic key_we,
  input wire logic [7:0] key_wdata,
  // Address and data writes
  input wire logic addr_high_we,
  input wire logic addr_low_we,
  input wire logic data_high_we,
  input wire logic data_low_we,
  input wire logic [7:0] byte_wdata,
  output logic [ADDR_W-1:0] flash_address,
  output logic [DATA_W-1:0] flash_data,
  // Processor control
  output logic cpu_force_nop,
  output logic cpu_stall,
  // Flash array
  output logic [ROW_W-1:0] flash_row,
  output logic flash_erase_start,
  output logic flash_word_we,
  output logic [IDX_W-1:0] flash_word_idx,
  output logic [DATA_W-1:0] flash_word_data
);
  logic rst_n;
  frs_state_t state_q, state_d;
  frs_key_t key_q, key_d;
  logic [ADDR_HI_W-1:0] adr_hi_q, adr_hi_d;
  logic [7:0] adr_lo_q, adr_lo_d;
  logic [DATA_HI_W-1:0] dat_hi_q, dat_hi_d;
  logic [7:0] dat_lo_q, dat_lo_d;
  logic en_q, en_d, cfg_q, cfg_d, latch_only_load_q, latch_only_load_d, ers_q, ers_d;
  logic wr_q, wr_d, err_q, err_d, mark_q, mark_d;
  logic op_erase_q, op_erase_d, op_latch_only_load_q, op_latch_only_load_d;
  logic [ROW_W-1:0] row_q, row_d;
  logic [IDX_W-1:0] idx_q, idx_d, ridx_q;
  logic [TMR_W-1:0] tmr_q, tmr_d;
  logic rdv_q, rdv_d, estart_q, estart_d;
  logic idle, other_we, start_try, go, done_op, busy;

  assign rst_n = resetn & por_n;

  frs_latch_if #(.AW(IDX_W), .DW(DATA_W)) lat ();

  frs_latch_mem #(.DEPTH(LATCHES)) u_frs_latch_mem (
    .clk(clk),
    .rst_n(rst_n),
    .lat(lat)
  );

  assign idle = (state_q == FRS_IDLE);
  assign other_we = ctrl_we | addr_high_we | addr_low_we |
    data_high_we | data_low_we;
  assign start_try = idle && ctrl_we && ctrl_wdata[CTRL_WRITE_START];
  assign go = start_try && (key_q == FRS_KEY_ARMED) &&
    ctrl_wdata[CTRL_PROG_EN] && !ctrl_wdata[CTRL_CFG_SPACE];

  // Unlock key tracker; any other write breaks the sequence
  always_comb
  begin
    key_d = key_q;
    if (key_we)
    begin
      if (key_wdata == KEY_FIRST)
        key_d = FRS_KEY_FIRST;
      else if (key_wdata == KEY_SECOND && key_q == FRS_KEY_FIRST)
        key_d = FRS_KEY_ARMED;
      else
        key_d = FRS_KEY_IDLE;
    end
    else if (other_we)
    begin
      key_d = FRS_KEY_IDLE;
    end
  end

  // Address and data byte registers
  always_comb
  begin
    adr_hi_d = adr_hi_q;
    adr_lo_d = adr_lo_q;
    dat_hi_d = dat_hi_q;
    dat_lo_d = dat_lo_q;
    if (idle && addr_high_we)
      adr_hi_d = byte_wdata[ADDR_HI_W-1:0];
    if (idle && addr_low_we)
      adr_lo_d = byte_wdata;
    if (idle && data_high_we)
      dat_hi_d = byte_wdata[DATA_HI_W-1:0];
    if (idle && data_low_we)
      dat_lo_d = byte_wdata;
  end

  // Sequencer
  always_comb
  begin
    state_d = state_q;
    op_erase_d = op_erase_q;
    op_latch_only_load_d = op_latch_only_load_q;
    row_d = row_q;
    idx_d = idx_q;
    tmr_d = tmr_q;
    estart_d = 1'b0;
    rdv_d = 1'b0;
    done_op = 1'b0;
    case (state_q)
      FRS_IDLE:
        if (go)
        begin
          op_erase_d = ctrl_wdata[CTRL_ERASE];
          op_latch_only_load_d = ctrl_wdata[CTRL_LATCH_ONLY];
          row_d = {adr_hi_q, adr_lo_q[7:IDX_W]};
          state_d = FRS_NOP1;
        end
      FRS_NOP1:
        state_d = FRS_NOP2;
      FRS_NOP2:
        if (op_erase_q)
        begin
          estart_d = 1'b1;
          tmr_d = TMR_W'(ERASE_CYCLES - 1);
          state_d = FRS_ERASE;
        end
        else if (op_latch_only_load_q)
        begin
          done_op = 1'b1;
          state_d = FRS_IDLE;
        end
        else
        begin
          idx_d = '0;
          state_d = FRS_PROG;
        end
      FRS_ERASE, FRS_PWAIT:
        if (tmr_q == '0)
          state_d = FRS_DONE;
        else
          tmr_d = tmr_q - TMR_W'(1);
      FRS_PROG:
      begin
        rdv_d = 1'b1;
        if (idx_q == IDX_W'(LATCHES - 1))
        begin
          tmr_d = TMR_W'(WRITE_CYCLES - 1);
          state_d = FRS_PWAIT;
        end
        else
          idx_d = idx_q + IDX_W'(1);
      end
      FRS_DONE:
      begin
        done_op = 1'b1;
        state_d = FRS_IDLE;
      end
      default:
        state_d = FRS_IDLE;
    endcase
  end

  // Latch port: load on accepted start unless erasing
  assign lat.we = go && !ctrl_wdata[CTRL_ERASE];
  assign lat.waddr = adr_lo_q[IDX_W-1:0];
  assign lat.wdata = {dat_hi_q, dat_lo_q};
  assign lat.clear = (state_q == FRS_DONE);
  assign lat.raddr = idx_q;

  assign busy = (state_q == FRS_ERASE) || (state_q == FRS_PROG) ||
    (state_q == FRS_PWAIT) || (state_q == FRS_DONE);

  // Control bits, error flag, reset-survivor mark
  always_comb
  begin
    en_d = en_q;
    cfg_d = cfg_q;
    latch_only_load_d = latch_only_load_q;
    ers_d = ers_q;
    wr_d = wr_q;
    err_d = err_q;
    if (idle && ctrl_we)
    begin
      en_d = ctrl_wdata[CTRL_PROG_EN];
      cfg_d = ctrl_wdata[CTRL_CFG_SPACE];
      latch_only_load_d = ctrl_wdata[CTRL_LATCH_ONLY];
      ers_d = ctrl_wdata[CTRL_ERASE];
      if (!ctrl_wdata[CTRL_ERROR])
        err_d = 1'b0;
    end
    if (go)
      wr_d = 1'b1;
    if (done_op)
    begin
      wr_d = 1'b0;
      if (op_erase_q)
        ers_d = 1'b0;
    end
    if (idle && mark_q)
      err_d = 1'b1;
    mark_d = busy && (state_q != FRS_DONE);
    if (!rst_n)
      mark_d = mark_q;
  end

  always_ff @(posedge clk or negedge por_n)
  begin
    if (!por_n)
      mark_q <= 1'b0;
    else
      mark_q <= mark_d;
  end

  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      state_q <= FRS_IDLE;
      key_q <= FRS_KEY_IDLE;
      adr_hi_q <= '0;
      adr_lo_q <= '0;
      dat_hi_q <= '0;
      dat_lo_q <= '0;
      en_q <= 1'b0;
      cfg_q <= 1'b0;
      latch_only_load_q <= 1'b0;
      ers_q <= 1'b0;
      wr_q <= 1'b0;
      err_q <= 1'b0;
      op_erase_q <= 1'b0;
      op_latch_only_load_q <= 1'b0;
      row_q <= '0;
      idx_q <= '0;
      ridx_q <= '0;
      tmr_q <= '0;
      rdv_q <= 1'b0;
      estart_q <= 1'b0;
    end
    else
    begin
      state_q <= state_d;
      key_q <= key_d;
      adr_hi_q <= adr_hi_d;
      adr_lo_q <= adr_lo_d;
      dat_hi_q <= dat_hi_d;
      dat_lo_q <= dat_lo_d;
      en_q <= en_d;
      cfg_q <= cfg_d;
      latch_only_load_q <= latch_only_load_d;
      ers_q <= ers_d;
      wr_q <= wr_d;
      err_q <= err_d;
      op_erase_q <= op_erase_d;
      op_latch_only_load_q <= op_latch_only_load_d;
      row_q <= row_d;
      idx_q <= idx_d;
      ridx_q <= idx_q;
      tmr_q <= tmr_d;
      rdv_q <= rdv_d;
      estart_q <= estart_d;
    end
  end

  assign ctrl_rdata = {1'b1, cfg_q, latch_only_load_q, ers_q, err_q, en_q, wr_q, 1'b0};
  assign flash_address = {adr_hi_q, adr_lo_q};
  assign flash_data = {dat_hi_q, dat_lo_q};
  assign cpu_force_nop = (state_q == FRS_NOP1) || (state_q == FRS_NOP2);
  assign cpu_stall = busy;
  assign flash_row = row_q;
  assign flash_erase_start = estart_q;
  assign flash_word_we = rdv_q;
  assign flash_word_idx = ridx_q;
  assign flash_word_data = lat.rdata;

  // Checks
  default clocking cb @(posedge clk); endclocking
  default disable iff (!rst_n);

  logic [5:0] words_q;
  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
      words_q <= '0;
    else if (idle)
      words_q <= '0;
    else if (flash_word_we)
      words_q <= words_q + 6'h01;
  end

  AST_NO_KEY_NO_START: assert property (
    start_try && (key_q != FRS_KEY_ARMED) |=> idle && !wr_q)
    else $error("start accepted without unlock");
  AST_NO_ENABLE_NO_START: assert property (
    start_try && !ctrl_wdata[CTRL_PROG_EN] |=> idle && !wr_q)
    else $error("start accepted without program enable");
  AST_TWO_NOPS: assert property (
    go |=> cpu_force_nop ##1 cpu_force_nop ##1 !cpu_force_nop)
    else $error("forced no-op count wrong");
  AST_ERASE_STALL: assert property (
    flash_erase_start |-> cpu_stall [*8])
    else $error("erase did not stall processor");
  AST_LATCH_ONLY_FAST: assert property (
    go && ctrl_wdata[CTRL_LATCH_ONLY] && !ctrl_wdata[CTRL_ERASE]
    |=> ##2 idle && !cpu_stall && !wr_q && !flash_word_we)
    else $error("latch-only load did not resume");
  AST_ROW_CAPTURE: assert property (
    go |=> flash_row == $past(flash_address[ADDR_W-1:IDX_W]))
    else $error("row not taken from upper address");
  AST_ROW_STABLE: assert property (
    flash_word_we |-> $stable(flash_row))
    else $error("row changed during program");
  AST_WORD_COUNT: assert property (
    state_q == FRS_DONE |->
    words_q == (op_erase_q ? 6'h00 : 6'(LATCHES)))
    else $error("wrong number of words programmed");
  AST_NO_AUTO_ERASE: assert property (
    flash_erase_start |-> op_erase_q && !flash_word_we)
    else $error("erase issued by program operation");
  AST_START_HW_CLEAR: assert property (
    $fell(wr_q) |-> $past(state_q == FRS_DONE || state_q == FRS_NOP2))
    else $error("start bit cleared outside completion");
  AST_ENABLE_HELD: assert property (
    state_q == FRS_NOP1 |-> en_q && !cfg_q)
    else $error("operation running without enable");
  AST_ERROR_CAUSE: assert property (
    $rose(err_q) |-> $past(mark_q))
    else $error("error flag set without interrupted operation");

  COV_ERASE: cover property (flash_erase_start ##[1:300] cpu_stall);
  COV_PROGRAM: cover property (state_q == FRS_PWAIT ##1 cpu_stall);
  COV_LATCH_LOAD: cover property (go && ctrl_wdata[CTRL_LATCH_ONLY]);
  COV_ERROR: cover property ($rose(err_q));
endmodule

// *** include/frs_pkg.sv ***
// Constants and types for the flash row erase/write sequencer
package frs_pkg;
  // Geometry
  localparam int ADDR_W = 15;
  localparam int ROW_W = 11;
  localparam int IDX_W = 4;
  localparam int DATA_W = 14;
  localparam int LATCHES = 16;
  localparam int ADDR_HI_W = 7;
  localparam int DATA_HI_W = 6;
  localparam logic [DATA_W-1:0] BLANK_WORD = 14'h3fff;
  // Unlock key bytes
  localparam logic [7:0] KEY_FIRST = 8'h55;
  localparam logic [7:0] KEY_SECOND = 8'haa;
  // Control register field positions
  localparam int CTRL_READ = 0;
  localparam int CTRL_WRITE_START = 1;
  localparam int CTRL_PROG_EN = 2;
  localparam int CTRL_ERROR = 3;
  localparam int CTRL_ERASE = 4;
  localparam int CTRL_LATCH_ONLY = 5;
  localparam int CTRL_CFG_SPACE = 6;
  localparam int CTRL_TOP = 7;
  // Timing
  localparam int CLK_KHZ = 10000;
  localparam int ERASE_TIME_US = 2000;
  localparam int WRITE_TIME_US = 2000;
  localparam int ERASE_CYC = (ERASE_TIME_US * CLK_KHZ) / 1000;
  localparam int WRITE_CYC = (WRITE_TIME_US * CLK_KHZ) / 1000;
  localparam int TMR_W = 24;

  typedef enum logic [6:0] {
    FRS_IDLE  = 7'h01,
    FRS_NOP1  = 7'h02,
    FRS_NOP2  = 7'h04,
    FRS_ERASE = 7'h08,
    FRS_PROG  = 7'h10,
    FRS_PWAIT = 7'h20,
    FRS_DONE  = 7'h40
  } frs_state_t;

  typedef enum logic [2:0] {
    FRS_KEY_IDLE  = 3'h1,
    FRS_KEY_FIRST = 3'h2,
    FRS_KEY_ARMED = 3'h4
  } frs_key_t;
endpackage

// *** include/frs_latch_if.sv ***
// Write latch array port between sequencer and latch memory
`timescale 1ns/1ps
interface frs_latch_if #(parameter int AW = 4, parameter int DW = 14);
  logic we;
  logic [AW-1:0] waddr;
  logic [DW-1:0] wdata;
  logic clear;
  logic [AW-1:0] raddr;
  logic [DW-1:0] rdata;
  modport mem (input we, waddr, wdata, clear, raddr, output rdata);
  modport seq (output we, waddr, wdata, clear, raddr, input rdata);
endinterface

// *** core/frs_latch_mem.sv ***
// Write latch memory with blank-on-clear and registered read
`timescale 1ns/1ps
module frs_latch_mem
  import frs_pkg::*;
#(
  parameter int DEPTH = LATCHES
)
(
  // Clock and reset
  input wire logic clk,
  input wire logic rst_n,
  // Latch port
  frs_latch_if.mem lat
);
  logic [DATA_W-1:0] mem_q [DEPTH];
  logic [DEPTH-1:0] vld_q;
  logic [DEPTH-1:0] vld_d;
  logic [DATA_W-1:0] rd_q;
  logic [DATA_W-1:0] rd_d;

  // Loaded flags; an unloaded entry reads blank
  for (genvar i = 0; i < DEPTH; i++)
  begin : g_vld
    assign vld_d[i] = lat.clear ? 1'b0 :
      ((lat.we && (int'(lat.waddr) == i)) ? 1'b1 : vld_q[i]);
  end

  always_comb
  begin
    rd_d = BLANK_WORD;
    if ((int'(lat.raddr) < DEPTH) && vld_q[lat.raddr])
    begin
      rd_d = mem_q[lat.raddr];
    end
  end

  always_ff @(posedge clk)
  begin
    if (lat.we && (int'(lat.waddr) < DEPTH))
    begin
      mem_q[lat.waddr] <= lat.wdata;
    end
  end

  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      vld_q <= '0;
      rd_q <= BLANK_WORD;
    end
    else
    begin
      vld_q <= vld_d;
      rd_q <= rd_d;
    end
  end

  assign lat.rdata = rd_q;

  AST_LATCH_BLANK: assert property (@(posedge clk) disable iff (!rst_n)
    lat.clear |=> (vld_q == '0))
    else $error("latches not blank after clear");
endmodule

// *** dv/frs_sequencer_tb.sv ***
// Self-checking testbench for the flash row erase/write sequencer
`timescale 1ns/1ps
module frs_sequencer_tb;
  import frs_pkg::*;
  localparam int EC = 20;
  localparam int WC = 20;
  localparam int K_CTRL = 0;
  localparam int K_KEY = 1;
  localparam int K_AH = 2;
  localparam int K_AL = 3;
  localparam int K_DH = 4;
  localparam int K_DL = 5;
  logic clk = 1'b0;
  logic resetn = 1'b0;
  logic por_n = 1'b0;
  logic ctrl_we = 1'b0;
  logic key_we = 1'b0;
  logic addr_high_we = 1'b0;
  logic addr_low_we = 1'b0;
  logic data_high_we = 1'b0;
  logic data_low_we = 1'b0;
  logic [7:0] ctrl_wdata = 8'h00;
  logic [7:0] key_wdata = 8'h00;
  logic [7:0] byte_wdata = 8'h00;
  logic [7:0] ctrl_rdata;
  logic [ADDR_W-1:0] flash_address;
  logic [DATA_W-1:0] flash_data;
  logic cpu_force_nop;
  logic cpu_stall;
  logic [ROW_W-1:0] flash_row;
  logic flash_erase_start;
  logic flash_word_we;
  logic [IDX_W-1:0] flash_word_idx;
  logic [DATA_W-1:0] flash_word_data;
  int miscompares = 0;
  int checks_done = 0;
  int nops, stalls, erases, wcnt;
  logic wr_seen;
  logic [ROW_W-1:0] row_seen;
  logic [DATA_W-1:0] words [LATCHES];
  logic [DATA_W-1:0] exp_w;

  frs_sequencer #(.ERASE_CYCLES(EC), .WRITE_CYCLES(WC)) u_frs_sequencer (
    .clk(clk), .resetn(resetn), .por_n(por_n),
    .ctrl_we(ctrl_we), .ctrl_wdata(ctrl_wdata), .ctrl_rdata(ctrl_rdata),
    .key_we(key_we), .key_wdata(key_wdata),
    .addr_high_we(addr_high_we), .addr_low_we(addr_low_we),
    .data_high_we(data_high_we), .data_low_we(data_low_we),
    .byte_wdata(byte_wdata), .flash_address(flash_address),
    .flash_data(flash_data), .cpu_force_nop(cpu_force_nop),
    .cpu_stall(cpu_stall), .flash_row(flash_row),
    .flash_erase_start(flash_erase_start), .flash_word_we(flash_word_we),
    .flash_word_idx(flash_word_idx), .flash_word_data(flash_word_data)
  );

  always #50 clk = ~clk;

  // Observe processor control and flash array activity
  always @(posedge clk)
  begin
    if (cpu_force_nop === 1'b1)
    begin
      nops++;
      if (ctrl_rdata[1] === 1'b1)
        wr_seen = 1'b1;
    end
    if (cpu_stall === 1'b1)
      stalls++;
    if (flash_erase_start === 1'b1)
    begin
      erases++;
      row_seen = flash_row;
    end
    if (flash_word_we === 1'b1)
    begin
      words[flash_word_idx] = flash_word_data;
      wcnt++;
      row_seen = flash_row;
    end
  end

  task automatic stop_test();
    $display("checks_done=%0d miscompares=%0d", checks_done, miscompares);
    if (miscompares == 0 && checks_done > 0)
      $display("RESULT: PASS");
    else
      $display("RESULT: FAIL");
    $finish;
  endtask

  task automatic chk(input logic [15:0] got, input logic [15:0] exp,
                     input string m);
    checks_done++;
    if (got !== exp)
    begin
      miscompares++;
      $display("MISMATCH t=%0t %s got %h exp %h", $time, m, got, exp);
    end
  endtask

  task automatic chk_rng(input int got, input int lo, input int hi,
                         input string m);
    checks_done++;
    if (got < lo || got > hi)
    begin
      miscompares++;
      $display("MISMATCH t=%0t %s got %0d", $time, m, got);
    end
  endtask

  task automatic clr();
    nops = 0;
    stalls = 0;
    erases = 0;
    wcnt = 0;
    wr_seen = 1'b0;
    row_seen = '0;
    for (int i = 0; i < LATCHES; i++)
      words[i] = '0;
  endtask

  // One register write strobe, held for one full clock
  task automatic wr(input int k, input logic [7:0] d);
    @(negedge clk);
    ctrl_wdata = d;
    key_wdata = d;
    byte_wdata = d;
    ctrl_we = (k == K_CTRL);
    key_we = (k == K_KEY);
    addr_high_we = (k == K_AH);
    addr_low_we = (k == K_AL);
    data_high_we = (k == K_DH);
    data_low_we = (k == K_DL);
    @(negedge clk);
    {ctrl_we, key_we, addr_high_we, addr_low_we} = 4'h0;
    {data_high_we, data_low_we} = 2'h0;
  endtask

  task automatic wait_idle();
    int i;
    for (i = 0; i < 500; i++)
    begin
      if (cpu_stall === 1'b0 && cpu_force_nop === 1'b0)
        break;
      @(negedge clk);
    end
    if (i == 500)
    begin
      miscompares++;
      $display("MISMATCH t=%0t sequencer never went idle", $time);
      stop_test();
    end
  endtask

  // Unlock key pair then start
  task automatic go(input logic [7:0] c);
    clr();
    wr(K_KEY, KEY_FIRST);
    wr(K_KEY, KEY_SECOND);
    wr(K_CTRL, c);
    wait_idle();
  endtask

  task automatic chk_words(input int n);
    for (int i = 0; i < LATCHES; i++)
    begin
      exp_w = BLANK_WORD;
      if (i == 9)
        exp_w = 14'h0f0f;
      else if (n == 3 && i == 7)
        exp_w = 14'h2a5c;
      else if (n == 3 && i == 8)
        exp_w = 14'h1111;
      chk(words[i], exp_w, "programmed word");
    end
  endtask

  initial
  begin
    clr();
    repeat (12) @(negedge clk);
    resetn = 1'b1;
    por_n = 1'b1;
    chk(ctrl_rdata, 8'h80, "control reset value");
    chk(flash_word_data, BLANK_WORD, "word data at reset");
    chk(cpu_stall, 1'b0, "stall at reset");
    wr(K_AH, 8'h12);
    wr(K_AL, 8'h37);
    chk(flash_address, 15'h1237, "address pair");
    wr(K_DH, 8'h2a);
    wr(K_DL, 8'h5c);
    chk(flash_data, 14'h2a5c, "data pair");
    go(8'h22);
    chk(nops, 0, "start without enable");
    chk(ctrl_rdata[1], 1'b0, "start bit without enable");
    wr(K_CTRL, 8'h04);
    go(8'h66);
    chk(nops, 0, "start with config space");
    go(8'h26);
    chk(nops, 2, "latch load no-op cycles");
    chk(stalls, 0, "latch load stall");
    chk(wcnt, 0, "latch load programs nothing");
    chk(wr_seen, 1'b1, "start bit during op");
    chk(ctrl_rdata[1], 1'b0, "start bit after op");
    chk(flash_address, 15'h1237, "no auto increment");
    wr(K_AL, 8'h38);
    wr(K_DH, 8'h11);
    wr(K_DL, 8'h11);
    go(8'h26);
    wr(K_AL, 8'h3a);
    wr(K_DH, 8'h33);
    clr();
    wr(K_KEY, KEY_FIRST);
    wr(K_DL, 8'h33);
    wr(K_KEY, KEY_SECOND);
    wr(K_CTRL, 8'h26);
    wait_idle();
    chk(nops, 0, "interrupted unlock");
    wr(K_KEY, KEY_SECOND);
    wr(K_KEY, KEY_FIRST);
    wr(K_CTRL, 8'h26);
    wait_idle();
    chk(nops, 0, "swapped key order");
    wr(K_AL, 8'h39);
    wr(K_DH, 8'h0f);
    wr(K_DL, 8'h0f);
    go(8'h06);
    chk(nops, 2, "program no-op cycles");
    chk(wcnt, LATCHES, "program word count");
    chk_rng(stalls, WC + 16, WC + 24, "program stall length");
    chk(row_seen, 11'h123, "program row");
    chk(erases, 0, "program erases nothing");
    chk_words(3);
    chk(ctrl_rdata[1], 1'b0, "start bit after program");
    go(8'h06);
    chk_words(1);
    wr(K_AH, 8'h05);
    wr(K_AL, 8'h6b);
    wr(K_CTRL, 8'h14);
    go(8'h16);
    chk(erases, 1, "one erase pulse");
    chk(row_seen, 11'h056, "erase row");
    chk(wcnt, 0, "erase writes no words");
    chk_rng(stalls, EC, EC + 3, "erase stall length");
    chk(nops, 2, "erase no-op cycles");
    chk(ctrl_rdata[4], 1'b0, "erase select cleared");
    // Load latch 9 from the data registers (still 0f0f) and program it into the erased row
    wr(K_AL, 8'h69);
    go(8'h06);
    chk(row_seen, 11'h056, "reprogram erased row");
    chk_words(1);
    clr();
    wr(K_KEY, KEY_FIRST);
    wr(K_KEY, KEY_SECOND);
    wr(K_CTRL, 8'h16);
    repeat (5) @(negedge clk);
    chk(cpu_stall, 1'b1, "stall in erase");
    resetn = 1'b0;
    repeat (2) @(negedge clk);
    resetn = 1'b1;
    repeat (3) @(negedge clk);
    chk(ctrl_rdata[3], 1'b1, "error after reset in erase");
    chk(ctrl_rdata[2], 1'b0, "enable after reset");
    wr(K_CTRL, 8'h08);
    chk(ctrl_rdata[3], 1'b1, "error kept by write of one");
    wr(K_CTRL, 8'h00);
    chk(ctrl_rdata[3], 1'b0, "error cleared by write");
    stop_test();
  end
endmodule
